// ===== src/gpib_chan_pkg.sv
package gpib_chan_pkg;
  localparam logic [4:0] ADDR_RESERVED = 5'h1f;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;
  localparam logic [1:0] GRP_SEC = 2'h3;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_GET = 7'h08;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_UNL = 7'h3f;
  localparam logic [6:0] CMD_UNT = 7'h5f;
  localparam logic [6:0] SEC_CHAN_A = 7'h61;
  localparam logic [6:0] SEC_CHAN_B = 7'h62;
  localparam logic [7:0] CH_F = 8'h46;
  localparam logic [7:0] CH_R = 8'h52;
  localparam logic [7:0] CH_M = 8'h4d;
  localparam logic [7:0] CH_T = 8'h54;
  localparam logic [7:0] CH_X = 8'h58;
  localparam logic [3:0] DIGIT_HI = 4'h3;
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [3:0] FUNC_MAX = 4'h2;
  localparam logic [3:0] MODE_MAX = 4'h1;
  localparam logic [3:0] TRIG_MAX = 4'h5;
  localparam logic [2:0] READING_BYTES = 3'h4;
  localparam logic [2:0] STATUS_BYTES = 3'h1;
  localparam logic [2:0] LAST_BYTE = 3'h1;
  localparam logic [7:0] BYTE_SHIFT = 8'h08;
  typedef enum logic [2:0] {
    continuous_on_talk, one_shot_on_talk, continuous_on_group_trigger,
    one_shot_on_group_trigger, continuous_on_execute, one_shot_on_execute
  } trig_mode_e;
  typedef struct packed {
    logic [1:0] func;
    logic [3:0] range;
    logic interrupt_response_mode;
  } chan_cfg_s;
  localparam chan_cfg_s CHAN_CFG_DEFAULT = '{func: 2'h0, range: 4'h0, interrupt_response_mode: 1'b0};
  typedef struct packed {logic valid; logic atn; logic [7:0] data;} bus_byte_s;
  typedef struct packed {logic ren; logic ifc;} bus_lines_s;
  typedef struct packed {logic valid; logic eoi; logic [7:0] data;} tx_byte_s;
endpackage

// ===== src/chan_status_word.sv
`timescale 1ns/1ps
`default_nettype none
module chan_status_word (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_clear,
  input wire logic i_load,
  input wire gpib_chan_pkg::chan_cfg_s i_load_cfg,
  input wire logic i_wr_func,
  input wire logic i_wr_range,
  input wire logic i_wr_mode,
  input wire logic [3:0] i_digit,
  input wire logic i_exec,
  output var gpib_chan_pkg::chan_cfg_s o_cfg
);
  import gpib_chan_pkg::*;
  chan_cfg_s pend_reg;
  logic [2:0] pend_v_reg;

  // pending fields wait for execute
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_cfg <= CHAN_CFG_DEFAULT;
      pend_reg <= CHAN_CFG_DEFAULT;
      pend_v_reg <= 3'h0;
    end else if (i_clear) begin
      o_cfg <= CHAN_CFG_DEFAULT;
      pend_v_reg <= 3'h0;
    end else if (i_exec) begin
      if (pend_v_reg[2]) o_cfg.func <= pend_reg.func;
      if (pend_v_reg[1]) o_cfg.range <= pend_reg.range;
      if (pend_v_reg[0]) o_cfg.interrupt_response_mode <= pend_reg.interrupt_response_mode;
      pend_v_reg <= 3'h0;
    end else begin
      if (i_load) o_cfg <= i_load_cfg;
      if (i_wr_func) begin
        pend_reg.func <= i_digit[1:0];
        pend_v_reg[2] <= 1'b1;
      end
      if (i_wr_range) begin
        pend_reg.range <= i_digit;
        pend_v_reg[1] <= 1'b1;
      end
      if (i_wr_mode) begin
        pend_reg.interrupt_response_mode <= i_digit[0];
        pend_v_reg[0] <= 1'b1;
      end
    end
  end
endmodule // chan_status_word
`default_nettype wire

// ===== src/byte_talker.sv
`timescale 1ns/1ps
`default_nettype none
module byte_talker (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_load,
  input wire logic [31:0] i_word,
  input wire logic [2:0] i_nbytes,
  input wire logic i_accept,
  input wire logic i_abort,
  output var gpib_chan_pkg::tx_byte_s o_tx,
  output logic o_done
);
  import gpib_chan_pkg::*;
  logic [31:0] shift_reg;
  logic [2:0] left_reg;

  // top byte first, end flag on the last byte only
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_tx <= '0;
      shift_reg <= 32'h0;
      left_reg <= 3'h0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_abort) begin
        o_tx.valid <= 1'b0;
        left_reg <= 3'h0;
      end else if (i_load) begin
        shift_reg <= i_word << BYTE_SHIFT;
        left_reg <= i_nbytes;
        o_tx <= '{valid: 1'b1, eoi: i_nbytes == LAST_BYTE, data: i_word[31:24]}; // [RULE10]
      end else if (o_tx.valid && i_accept) begin
        if (left_reg == LAST_BYTE) begin
          o_tx.valid <= 1'b0;
          o_done <= 1'b1;
        end else begin
          o_tx.data <= shift_reg[31:24];
          o_tx.eoi <= (left_reg - 3'h1) == LAST_BYTE; // [RULE10]
          shift_reg <= shift_reg << BYTE_SHIFT;
        end
        left_reg <= left_reg - 3'h1;
      end
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  property p_eoi_last;
    o_tx.valid && i_accept && !i_abort && o_tx.eoi |=> !o_tx.valid && o_done;
  endproperty
  a_eoi_last: assert property (p_eoi_last) else $error("byte after end flag"); // [RULE10]
  property p_no_early_eoi;
    o_tx.valid && i_accept && !i_abort && !o_tx.eoi |=> o_tx.valid && !o_done;
  endproperty
  a_no_early_eoi: assert property (p_no_early_eoi) else $error("transfer ended without end flag"); // [RULE10]
endmodule // byte_talker
`default_nettype wire

// ===== src/gpib_channel_command_handler.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE1 - five switch address, all ones refused
// RULE2 - controller sends address then channel secondary
// RULE3 - remote entry: enable plus listen address
// RULE4 - programming only in remote, else message
// RULE5 - lockout freezes panel, lights annunciator
// RULE6 - ratio button triggers while awaiting trigger
// RULE7 - display shows new setup after trigger
// RULE8 - interface clear idles talker and listener
// RULE9 - service request, poll enable sends status
// RULE10 - end flag on final byte only
// RULE11 - device clear, selected clear when listening
// RULE12 - untalk and unlisten idle their functions
// RULE13 - group trigger only listening, group modes
// RULE14 - commands held until execute arrives
// RULE15 - per channel status, selected channel only
// RULE16 - standard mode no request, interrupt mode requests
// RULE17 - continuous on talk holds unread reading
// RULE18 - one shot on each talk address
// RULE19 - group trigger continuous and one shot
// RULE20 - execute continuous and one shot
// RULE21 - one trigger mode, default continuous on talk
module gpib_channel_command_handler (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic [4:0] i_addr_sw,
  input wire gpib_chan_pkg::bus_lines_s i_lines,
  input wire gpib_chan_pkg::bus_byte_s i_rx,
  input wire logic i_tx_accept,
  input wire logic i_panel_ratio,
  input wire logic i_panel_wr,
  input wire logic i_panel_chan,
  input wire gpib_chan_pkg::chan_cfg_s i_panel_cfg,
  input wire logic i_conv_done,
  input wire logic [31:0] i_conv_result,
  output var gpib_chan_pkg::tx_byte_s o_tx,
  output logic o_conv_start,
  output logic o_conv_chan,
  output logic o_remote,
  output logic o_lockout,
  output logic o_not_remote,
  output logic o_talker,
  output logic o_listener,
  output logic o_srq,
  output var gpib_chan_pkg::chan_cfg_s o_disp_cfg,
  output var gpib_chan_pkg::trig_mode_e o_trig_mode,
  output var gpib_chan_pkg::chan_cfg_s o_chan_a_cfg,
  output var gpib_chan_pkg::chan_cfg_s o_chan_b_cfg
);
  import gpib_chan_pkg::*;

  logic own_ok, rx_cmd, rx_dat;
  logic is_mla, is_mta, is_ota, is_unl, is_unt, is_sec;
  logic is_dcl, is_sdc, is_llo, is_spe, is_spd, is_get;
  logic dev_clear, data_ok, is_digit, exec, bad_arg;
  logic wr_func, wr_range, wr_mode, wr_trig;
  logic [3:0] digit;
  logic [1:0] grp;
  logic [6:0] cmd7;
  logic sec_wait_reg, spe_reg, poll_sent_reg;
  logic [7:0] letter_reg;
  logic pend_trig_v_reg;
  trig_mode_e pend_trig_reg, trig_apply;
  logic run_reg, shot_reg, conv_busy_reg, buf_full_reg, buf_chan_reg, tx_rd_reg;
  logic [31:0] buf_reg;
  logic start, waiting, talk_trig, get_trig, x_trig, manual;
  logic data_evt, err_reg, srq_set, tx_load, tx_done, tx_abort;
  logic [31:0] tx_word;
  logic [2:0] tx_nbytes;
  logic [7:0] status_byte;
  chan_cfg_s sel_cfg, buf_cfg;

  // bus byte decode
  assign own_ok = i_addr_sw != ADDR_RESERVED; // [RULE1]
  assign rx_cmd = i_rx.valid && i_rx.atn;
  assign rx_dat = i_rx.valid && !i_rx.atn;
  assign grp = i_rx.data[6:5];
  assign cmd7 = i_rx.data[6:0];
  assign is_mla = rx_cmd && grp == GRP_LISTEN && i_rx.data[4:0] == i_addr_sw && own_ok; // [RULE1]
  assign is_mta = rx_cmd && grp == GRP_TALK && i_rx.data[4:0] == i_addr_sw && own_ok; // [RULE1]
  assign is_ota = rx_cmd && grp == GRP_TALK && !is_mta;
  assign is_unl = rx_cmd && cmd7 == CMD_UNL;
  assign is_unt = rx_cmd && cmd7 == CMD_UNT;
  assign is_sec = rx_cmd && grp == GRP_SEC && sec_wait_reg;
  assign is_dcl = rx_cmd && cmd7 == CMD_DCL;
  assign is_sdc = rx_cmd && cmd7 == CMD_SDC;
  assign is_llo = rx_cmd && cmd7 == CMD_LLO;
  assign is_spe = rx_cmd && cmd7 == CMD_SPE;
  assign is_spd = rx_cmd && cmd7 == CMD_SPD;
  assign is_get = rx_cmd && cmd7 == CMD_GET;
  assign dev_clear = is_dcl || (is_sdc && o_listener); // [RULE11]

  // device dependent command parse
  assign data_ok = rx_dat && o_listener && o_remote; // [RULE4]
  assign digit = i_rx.data[3:0];
  assign is_digit = i_rx.data[7:4] == DIGIT_HI && digit <= DIGIT_MAX;
  assign exec = data_ok && i_rx.data == CH_X; // [RULE14]
  assign wr_func = data_ok && is_digit && letter_reg == CH_F && digit <= FUNC_MAX;
  assign wr_range = data_ok && is_digit && letter_reg == CH_R;
  assign wr_mode = data_ok && is_digit && letter_reg == CH_M && digit <= MODE_MAX;
  assign wr_trig = data_ok && is_digit && letter_reg == CH_T && digit <= TRIG_MAX;
  assign bad_arg = data_ok && is_digit && !(wr_func || wr_range || wr_mode || wr_trig);
  assign trig_apply = pend_trig_v_reg ? pend_trig_reg : o_trig_mode;

  // trigger sources
  assign talk_trig = is_mta && (o_trig_mode == continuous_on_talk || o_trig_mode == one_shot_on_talk); // [RULE17] [RULE18]
  assign get_trig = is_get && o_listener && (o_trig_mode == continuous_on_group_trigger ||
                    o_trig_mode == one_shot_on_group_trigger); // [RULE13] [RULE19]
  assign x_trig = exec && (trig_apply == continuous_on_execute || trig_apply == one_shot_on_execute); // [RULE20]
  assign waiting = !run_reg && !shot_reg && !conv_busy_reg;
  assign manual = i_panel_ratio && waiting; // [RULE6]
  assign start = (run_reg || shot_reg) && !conv_busy_reg && !buf_full_reg; // [RULE17]
  assign sel_cfg = o_conv_chan ? o_chan_b_cfg : o_chan_a_cfg;
  assign buf_cfg = buf_chan_reg ? o_chan_b_cfg : o_chan_a_cfg;

  // status and talk source
  assign data_evt = i_conv_done && conv_busy_reg;
  assign srq_set = (data_evt && buf_cfg.interrupt_response_mode) ||
                   (bad_arg && sel_cfg.interrupt_response_mode); // [RULE16]
  assign status_byte = {1'b0, o_srq, 3'h0, buf_chan_reg, err_reg, buf_full_reg};
  assign tx_abort = i_lines.ifc || is_unt || is_ota;
  assign tx_load = o_talker && !o_tx.valid && !tx_abort &&
                   (spe_reg ? !poll_sent_reg : buf_full_reg); // [RULE9]
  assign tx_word = spe_reg ? {status_byte, 24'h0} : buf_reg;
  assign tx_nbytes = spe_reg ? STATUS_BYTES : READING_BYTES;

  // talker and listener addressing
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_listener <= 1'b0;
      o_talker <= 1'b0;
      o_conv_chan <= 1'b0;
      sec_wait_reg <= 1'b0;
    end else if (i_lines.ifc) begin
      o_listener <= 1'b0; // [RULE8]
      o_talker <= 1'b0; // [RULE8]
      sec_wait_reg <= 1'b0;
    end else if (rx_cmd) begin
      sec_wait_reg <= is_mla || is_mta;
      if (is_mla) o_listener <= 1'b1;
      if (is_unl) o_listener <= 1'b0; // [RULE12]
      if (is_mta) o_talker <= 1'b1;
      if (is_ota) o_talker <= 1'b0; // [RULE12]
      if (is_sec && cmd7 == SEC_CHAN_A) o_conv_chan <= 1'b0; // [RULE2] [RULE15]
      if (is_sec && cmd7 == SEC_CHAN_B) o_conv_chan <= 1'b1; // [RULE2] [RULE15]
    end
  end

  // remote, lockout and not-remote message
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_remote <= 1'b0;
      o_lockout <= 1'b0;
      o_not_remote <= 1'b0;
    end else if (!i_lines.ren) begin
      o_remote <= 1'b0;
      o_lockout <= 1'b0;
      if (rx_dat && o_listener) o_not_remote <= 1'b1; // [RULE4]
    end else begin
      if (is_mla) begin
        o_remote <= 1'b1; // [RULE3]
        o_not_remote <= 1'b0;
      end else if (rx_dat && o_listener && !o_remote) begin
        o_not_remote <= 1'b1; // [RULE4]
      end
      if (is_llo) o_lockout <= 1'b1; // [RULE5]
    end
  end

  // serial poll state
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      spe_reg <= 1'b0;
      poll_sent_reg <= 1'b0;
    end else begin
      if (i_lines.ifc || is_spd) spe_reg <= 1'b0; // [RULE9]
      else if (is_spe) spe_reg <= 1'b1; // [RULE9]
      if (is_mta || is_spe) poll_sent_reg <= 1'b0;
      else if (tx_load && spe_reg) poll_sent_reg <= 1'b1;
    end
  end

  // letter tracking and pending trigger mode
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      letter_reg <= 8'h0;
      pend_trig_v_reg <= 1'b0;
      pend_trig_reg <= continuous_on_talk;
      o_trig_mode <= continuous_on_talk;
    end else if (dev_clear) begin
      pend_trig_v_reg <= 1'b0;
      o_trig_mode <= continuous_on_talk; // [RULE21] [RULE11]
    end else if (data_ok) begin
      letter_reg <= i_rx.data;
      if (wr_trig) begin
        pend_trig_reg <= trig_mode_e'(digit[2:0]); // [RULE14]
        pend_trig_v_reg <= 1'b1;
      end
      if (exec) begin
        o_trig_mode <= trig_apply; // [RULE21] [RULE14]
        pend_trig_v_reg <= 1'b0;
      end
    end
  end

  // conversion arming and output buffer
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      run_reg <= 1'b0;
      shot_reg <= 1'b0;
      conv_busy_reg <= 1'b0;
      buf_full_reg <= 1'b0;
      buf_chan_reg <= 1'b0;
      buf_reg <= 32'h0;
      o_conv_start <= 1'b0;
      tx_rd_reg <= 1'b0;
    end else begin
      o_conv_start <= start;
      if (dev_clear) begin
        run_reg <= 1'b0;
        shot_reg <= 1'b0;
      end else if (x_trig) begin
        run_reg <= trig_apply == continuous_on_execute; // [RULE20]
        shot_reg <= trig_apply == one_shot_on_execute; // [RULE20]
      end else if (talk_trig || get_trig) begin
        run_reg <= o_trig_mode == continuous_on_talk ||
                   o_trig_mode == continuous_on_group_trigger; // [RULE17] [RULE19]
        shot_reg <= o_trig_mode == one_shot_on_talk ||
                    o_trig_mode == one_shot_on_group_trigger; // [RULE18] [RULE19]
      end else if (exec && trig_apply != o_trig_mode) begin
        run_reg <= 1'b0;
        shot_reg <= 1'b0;
      end else if (manual) begin
        shot_reg <= 1'b1; // [RULE6]
      end else if (start) begin
        shot_reg <= 1'b0;
      end
      if (start) begin
        conv_busy_reg <= 1'b1;
      end else if (data_evt) begin
        conv_busy_reg <= 1'b0;
        buf_reg <= i_conv_result;
        buf_chan_reg <= o_conv_chan;
      end
      if (tx_load) tx_rd_reg <= !spe_reg;
      if (data_evt) buf_full_reg <= 1'b1;
      else if (tx_done && tx_rd_reg) buf_full_reg <= 1'b0; // [RULE17]
    end
  end

  // display follows trigger
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) o_disp_cfg <= CHAN_CFG_DEFAULT;
    else if (start) o_disp_cfg <= sel_cfg; // [RULE7]
  end

  // service request and error, set wins over clear
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_srq <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      if (srq_set) o_srq <= 1'b1; // [RULE16]
      else if (dev_clear || (tx_load && spe_reg)) o_srq <= 1'b0; // [RULE9]
      if (bad_arg) err_reg <= 1'b1;
      else if (dev_clear || (tx_load && spe_reg)) err_reg <= 1'b0;
    end
  end

  chan_status_word u_chan_a (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_clear(dev_clear), // [RULE11]
    .i_load(i_panel_wr && !o_lockout && !i_panel_chan), // [RULE5]
    .i_load_cfg(i_panel_cfg),
    .i_wr_func(wr_func && !o_conv_chan), // [RULE15]
    .i_wr_range(wr_range && !o_conv_chan),
    .i_wr_mode(wr_mode && !o_conv_chan),
    .i_digit(digit),
    .i_exec(exec && !o_conv_chan), // [RULE14]
    .o_cfg(o_chan_a_cfg)
  );

  chan_status_word u_chan_b (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_clear(dev_clear),
    .i_load(i_panel_wr && !o_lockout && i_panel_chan), // [RULE5]
    .i_load_cfg(i_panel_cfg),
    .i_wr_func(wr_func && o_conv_chan), // [RULE15]
    .i_wr_range(wr_range && o_conv_chan),
    .i_wr_mode(wr_mode && o_conv_chan),
    .i_digit(digit),
    .i_exec(exec && o_conv_chan),
    .o_cfg(o_chan_b_cfg)
  );

  byte_talker u_talker (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_load(tx_load),
    .i_word(tx_word),
    .i_nbytes(tx_nbytes),
    .i_accept(i_tx_accept),
    .i_abort(tx_abort),
    .o_tx(o_tx),
    .o_done(tx_done)
  );

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);

  property p_reserved_addr;
    rx_cmd && grp == GRP_LISTEN && i_rx.data[4:0] == ADDR_RESERVED && !o_listener |=> !o_listener;
  endproperty
  a_reserved_addr: assert property (p_reserved_addr) else $error("reserved address accepted"); // [RULE1]
  property p_not_remote;
    rx_dat && o_listener && !o_remote |=> o_not_remote && $stable(o_chan_a_cfg) && $stable(o_chan_b_cfg);
  endproperty
  a_not_remote: assert property (p_not_remote) else $error("programmed outside remote"); // [RULE4]
  property p_lockout;
    o_lockout && i_panel_wr && !dev_clear && !exec |=> $stable(o_chan_a_cfg) && $stable(o_chan_b_cfg);
  endproperty
  a_lockout: assert property (p_lockout) else $error("panel changed setup under lockout"); // [RULE5]
  property p_disp_hold;
    $changed(o_disp_cfg) |-> $past(start);
  endproperty
  a_disp_hold: assert property (p_disp_hold) else $error("display changed without trigger"); // [RULE7]
  property p_ifc;
    i_lines.ifc && !dev_clear |=> !o_talker && !o_listener && $stable(o_trig_mode) && $stable(o_chan_a_cfg);
  endproperty
  a_ifc: assert property (p_ifc) else $error("interface clear misbehaved"); // [RULE8]
  property p_dcl;
    is_dcl |=> o_trig_mode == continuous_on_talk && o_chan_a_cfg == CHAN_CFG_DEFAULT &&
      o_chan_b_cfg == CHAN_CFG_DEFAULT;
  endproperty
  a_dcl: assert property (p_dcl) else $error("device clear missed defaults"); // [RULE11] [RULE21]
  property p_untalk;
    is_unt |=> !o_talker;
  endproperty
  a_untalk: assert property (p_untalk) else $error("still talker after untalk"); // [RULE12]
  property p_get;
    is_get && o_listener && o_trig_mode == one_shot_on_group_trigger && !i_lines.ifc && !conv_busy_reg &&
      !buf_full_reg && !data_evt |=> ##1 o_conv_start;
  endproperty
  a_get: assert property (p_get) else $error("group trigger did not convert"); // [RULE13]
  property p_hold_buf;
    buf_full_reg && !tx_done |=> $stable(buf_reg) && buf_full_reg;
  endproperty
  a_hold_buf: assert property (p_hold_buf) else $error("unread reading overwritten"); // [RULE17]
  property p_std_mode;
    !o_srq && !sel_cfg.interrupt_response_mode && !buf_cfg.interrupt_response_mode |=> !o_srq;
  endproperty
  a_std_mode: assert property (p_std_mode) else $error("request raised in standard mode"); // [RULE16]

  c_get_shot: cover property (get_trig ##[1:20] o_conv_start);
  c_poll: cover property (spe_reg && tx_load ##[1:5] o_tx.eoi);
  c_read: cover property (tx_done && o_trig_mode == continuous_on_talk);
  c_exec: cover property (x_trig ##[1:20] o_conv_start);
endmodule // gpib_channel_command_handler
`default_nettype wire

// ===== dv/gpib_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module gpib_ctrl_model (
  input wire logic i_ref_clk,
  input wire gpib_chan_pkg::tx_byte_s i_tx,
  output var gpib_chan_pkg::bus_byte_s o_rx,
  output var gpib_chan_pkg::bus_lines_s o_lines,
  output logic o_accept
);
  import gpib_chan_pkg::*;
  logic [8:0] got[$];
  initial begin
    o_rx = '0;
    o_lines = '0;
    o_accept = 1'b0;
  end
  // acceptor stalls at random
  always @(negedge i_ref_clk) o_accept <= 1'($urandom_range(1, 0));
  always @(posedge i_ref_clk) if (i_tx.valid === 1'b1 && o_accept) got.push_back({i_tx.eoi, i_tx.data});
  // one handshaken byte, then lines show the inverse
  task automatic send(input logic atn, input logic [7:0] b);
    @(negedge i_ref_clk);
    o_rx <= '{valid: 1'b1, atn: atn, data: b};
    @(negedge i_ref_clk);
    o_rx <= '{valid: 1'b0, atn: ~atn, data: ~b};
  endtask
  task automatic text(input string s);
    foreach (s[k]) send(1'b0, s[k]);
  endtask
  // primary address then channel secondary
  task automatic addr(input logic talk, input logic [4:0] a, input logic [6:0] sec);
    send(1'b1, {1'b0, talk, ~talk, a});
    send(1'b1, {1'b0, sec});
  endtask
  task automatic set_lines(input logic ren, input logic ifc);
    @(negedge i_ref_clk);
    o_lines <= '{ren: ren, ifc: ifc};
  endtask
endmodule // gpib_ctrl_model
`default_nettype wire

// ===== dv/gpib_channel_command_handler_bench.sv
`timescale 1ns/1ps
`default_nettype none
module gpib_channel_command_handler_bench;
  import gpib_chan_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] sw = 5'h1f;
  logic ratio = 1'b0;
  logic pwr = 1'b0;
  logic pch = 1'b1;
  logic cdone = 1'b0;
  logic [31:0] cres = '0;
  logic [31:0] last = '0;
  chan_cfg_s pcfg = CHAN_CFG_DEFAULT;
  bus_byte_s rx;
  bus_lines_s lines;
  tx_byte_s tx;
  logic acc, cstart, cch, rem, llo, nrem, tlk, lsn, srq;
  chan_cfg_s disp, cfg_a, cfg_b;
  trig_mode_e tmode;
  int failures = 0;
  int n_checks = 0;
  int nconv = 0;
  int n0 = 0;
  int mf[3] = '{0, 0, 0};
  int mr[3] = '{0, 0, 0};
  logic [4:0] a;
  always #5 clk = ~clk;
  gpib_channel_command_handler dut (.i_ref_clk(clk), .i_arst_n(arst_n), .i_addr_sw(sw), .i_lines(lines),
    .i_rx(rx), .i_tx_accept(acc), .i_panel_ratio(ratio), .i_panel_wr(pwr), .i_panel_chan(pch),
    .i_panel_cfg(pcfg), .i_conv_done(cdone), .i_conv_result(cres), .o_tx(tx), .o_conv_start(cstart),
    .o_conv_chan(cch), .o_remote(rem), .o_lockout(llo), .o_not_remote(nrem), .o_talker(tlk), .o_listener(lsn),
    .o_srq(srq), .o_disp_cfg(disp), .o_trig_mode(tmode), .o_chan_a_cfg(cfg_a), .o_chan_b_cfg(cfg_b));
  gpib_ctrl_model ctrl (.i_ref_clk(clk), .i_tx(tx), .o_rx(rx), .o_lines(lines), .o_accept(acc));
  task automatic fail(input string m);
    failures++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic chk_lvl(input logic g, input logic e, input string m);
    n_checks++;
    if (g !== e) fail(m);
  endtask
  task automatic chk_cfg(input chan_cfg_s g, input int c, input string m);
    n_checks++;
    if (g !== chan_cfg_s'{func: 2'(mf[c]), range: 4'(mr[c]), interrupt_response_mode: 1'b0}) fail(m);
  endtask
  task automatic chk_byte(input int i, input logic [8:0] e);
    n_checks++;
    if (ctrl.got[i] !== e) fail("talker byte");
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wconv();
    repeat (30) if (nconv == n0) @(negedge clk);
  endtask
  task automatic pulse_panel();
    pwr = 1'b1;
    tick(1);
    pwr = 1'b0;
    tick(2);
  endtask
  task automatic print_verdict();
    if (failures == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // converter answers each start with a random reading
  always begin
    @(posedge clk);
    #1;
    if (cstart === 1'b1) begin
      @(negedge clk);
      last = $urandom;
      cres = last;
      cdone = 1'b1;
      nconv++;
      @(negedge clk);
      cdone = 1'b0;
    end
  end
  initial begin
    #300000;
    fail("timeout");
    print_verdict();
  end
  initial begin
    void'($urandom(32'hbde838f8));
    a = 5'($urandom_range(30, 0));
    tick(20);
    arst_n = 1'b1;
    tick(1);
    chk_lvl(tmode === continuous_on_talk, 1'b1, "trig default");
    chk_cfg(cfg_a, 0, "cfg default");
    ctrl.set_lines(1'b1, 1'b0);
    ctrl.send(1'b1, 8'h3f);
    tick(2);
    chk_lvl(lsn | rem, 1'b0, "reserved address");
    sw = a;
    ctrl.set_lines(1'b0, 1'b0);
    ctrl.addr(1'b0, a, SEC_CHAN_A);
    ctrl.text("F1X");
    tick(2);
    chk_lvl(nrem, 1'b1, "not remote");
    chk_cfg(cfg_a, 0, "local programming");
    ctrl.set_lines(1'b1, 1'b0);
    ctrl.send(1'b1, {3'h1, a});
    tick(2);
    chk_lvl(rem & lsn, 1'b1, "remote entry");
    ctrl.addr(1'b0, a, SEC_CHAN_A);
    ctrl.text("F1");
    tick(2);
    chk_cfg(cfg_a, 0, "early apply");
    ctrl.text("R2X");
    mf[0] = 1;
    mr[0] = 2;
    tick(2);
    chk_cfg(cfg_a, 0, "split commands");
    chk_cfg(cfg_b, 1, "wrong channel");
    mf[1] = $urandom_range(2, 0);
    mr[1] = $urandom_range(9, 0);
    ctrl.addr(1'b0, a, SEC_CHAN_B);
    ctrl.text($sformatf("F%0dR%0dX", mf[1], mr[1]));
    tick(2);
    chk_cfg(cfg_b, 1, "channel b");
    chk_lvl(cch, 1'b1, "channel select");
    chk_cfg(disp, 2, "display early");
    ctrl.addr(1'b0, a, SEC_CHAN_A);
    n0 = nconv;
    for (int k = 0; k < 6; k++) if (k != 4) begin
      ctrl.text($sformatf("T%0dX", k));
      tick(2);
      chk_lvl(tmode === trig_mode_e'(k), 1'b1, "trig mode");
    end
    wconv();
    tick(10);
    chk_lvl(nconv == n0 + 1, 1'b1, "one shot on execute");
    chk_cfg(disp, 0, "display after trigger");
    ctrl.addr(1'b1, a, SEC_CHAN_A);
    repeat (60) if (ctrl.got.size() < 4) @(negedge clk);
    for (int i = 0; i < 4; i++) chk_byte(i, {i == 3, last[31 - 8 * i -: 8]});
    ctrl.send(1'b1, {1'b0, CMD_UNT});
    tick(2);
    chk_lvl(tlk, 1'b0, "untalk");
    ctrl.got.delete();
    n0 = nconv;
    ctrl.send(1'b1, {1'b0, CMD_GET});
    tick(6);
    chk_lvl(nconv == n0, 1'b1, "group trigger");
    ratio = 1'b1;
    tick(1);
    ratio = 1'b0;
    wconv();
    chk_lvl(nconv == n0 + 1, 1'b1, "ratio trigger");
    ctrl.send(1'b1, {1'b0, CMD_SPE});
    ctrl.addr(1'b1, a, SEC_CHAN_A);
    repeat (60) if (ctrl.got.size() < 1) @(negedge clk);
    chk_lvl((ctrl.got[0] & 9'h1fd) === 9'h101, 1'b1, "poll status");
    chk_lvl(srq, 1'b0, "standard mode request");
    ctrl.send(1'b1, {1'b0, CMD_SPD});
    repeat (80) if (ctrl.got.size() < 5) @(negedge clk);
    for (int i = 0; i < 4; i++) chk_byte(i + 1, {i == 3, last[31 - 8 * i -: 8]});
    ctrl.send(1'b1, {1'b0, CMD_UNT});
    ctrl.send(1'b1, {1'b0, CMD_UNL});
    tick(2);
    chk_lvl(lsn | tlk, 1'b0, "unlisten");
    pch = 1'($urandom);
    pcfg.func = 2'($urandom_range(2, 0));
    pcfg.range = 4'($urandom_range(9, 0));
    mf[pch] = pcfg.func;
    mr[pch] = pcfg.range;
    pulse_panel();
    chk_cfg(pch ? cfg_b : cfg_a, pch, "panel write");
    ctrl.send(1'b1, {1'b0, CMD_LLO});
    tick(2);
    chk_lvl(llo, 1'b1, "lockout");
    pcfg.range = 4'((mr[pch] + 1) % 10);
    pulse_panel();
    chk_cfg(pch ? cfg_b : cfg_a, pch, "panel under lockout");
    ctrl.addr(1'b0, a, SEC_CHAN_A);
    ctrl.set_lines(1'b1, 1'b1);
    ctrl.set_lines(1'b1, 1'b0);
    tick(2);
    chk_lvl(lsn, 1'b0, "interface clear");
    chk_cfg(cfg_a, 0, "clear kept setup");
    ctrl.addr(1'b0, a, SEC_CHAN_A);
    ctrl.text("T3X");
    n0 = nconv;
    ctrl.send(1'b1, {1'b0, CMD_GET});
    wconv();
    chk_lvl(nconv == n0 + 1, 1'b1, "group trigger one shot");
    ctrl.text("T4X");
    tick(2);
    chk_lvl(tmode === continuous_on_execute, 1'b1, "continuous on execute");
    ctrl.text("M1XF9");
    tick(2);
    chk_lvl(srq, 1'b1, "interrupt request");
    ctrl.send(1'b1, {1'b0, CMD_DCL});
    tick(4);
    mf[0] = 0;
    mr[0] = 0;
    chk_lvl(tmode === continuous_on_talk, 1'b1, "clear mode");
    chk_cfg(cfg_a, 0, "clear setup");
    chk_lvl(srq, 1'b0, "clear request");
    print_verdict();
  end
endmodule // gpib_channel_command_handler_bench
`default_nettype wire
